/* omr_pkg.sv */
// Function
// [R1] Bit 7 routes left amp pair to common.
// [R2] Bit 7 routes first left converter to common.
// [R3] Bit 7 routes second right line to common.
// [R4] Bit 7 routes right amp pair to common.
// [R5] Bit 7 routes first right converter to common.
// [R6] Bit 7 routes second left line to headphone.
// [R7] Bit 7 routes left amp pair to headphone.
// [R8] Route bits 6..0 hold gain, reset zero.
// [R9] Level bits 7..4 set 0 to 9 dB.
// [R10] Software never writes level codes 1010..1111.
// [R11] Level bit 3 zero mutes; reset muted.
// [R12] Level bit 2 picks powered-down drive, reset one.
// [R13] Level bit 1 reads gain pending, reset one.
// [R14] Level bit 0 one fully powers output up.
// [R15] Writes never touch the pending status bit.
package omr_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int GAIN_W = 7;
   localparam int LEVEL_W = 4;

   // Register numbers; each is its own byte address on the control port.
   localparam logic [7:0] ADDR_LPGA_LCOM = 8'h35;
   localparam logic [7:0] ADDR_LDAC_LCOM = 8'h36;
   localparam logic [7:0] ADDR_RLN2_LCOM = 8'h37;
   localparam logic [7:0] ADDR_RPGA_LCOM = 8'h38;
   localparam logic [7:0] ADDR_RDAC_LCOM = 8'h39;
   localparam logic [7:0] ADDR_LCOM_LEVEL = 8'h3A;
   localparam logic [7:0] ADDR_LLN2_RHP = 8'h3B;
   localparam logic [7:0] ADDR_LPGA_RHP = 8'h3C;

   // Route register fields.
   localparam int ROUTE_EN_BIT = 7;
   localparam logic [7:0] ROUTE_RESET = 8'h00;

   // Level control register fields.
   localparam int LEVEL_LSB = 4;
   localparam int UNMUTE_BIT = 3;
   localparam int PD_HIZ_BIT = 2;
   localparam int PENDING_BIT = 1;
   localparam int POWER_BIT = 0;
   localparam logic [3:0] LEVEL_RESET = 4'h0;
   localparam logic LEVEL_MAX_NUM = 1'b1;
   localparam logic [3:0] LEVEL_MAX = 4'h9;
   localparam logic UNMUTE_RESET = 1'b0;
   localparam logic PD_HIZ_RESET = 1'b1;
   localparam logic PENDING_RESET = 1'b1;
   localparam logic POWER_RESET = 1'b0;

   // Soft-step pacing of gain changes.
   localparam int CLK_MHZ = 125;
   localparam int STEP_TIME_NS = 1000;
   localparam int STEP_CYCLES = (STEP_TIME_NS * CLK_MHZ) / 1000;

   localparam int N_ROUTES = 7;
   localparam int N_LCOM_ROUTES = 5;

   typedef struct packed {
      logic              en;
      logic [GAIN_W-1:0] gain;
   } omr_route_t;

   typedef struct packed {
      logic [LEVEL_W-1:0] level;
      logic               unmute;
      logic               pd_hiz;
      logic               pending;
      logic               power;
   } omr_level_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RAMP = 3'b010,
      ST_HOLD = 3'b100
   } omr_state_t;

endpackage

/* omr_step_div.sv */
`timescale 1ns/1ps
module omr_step_div #(
   parameter int DIV = omr_pkg::STEP_CYCLES
) (
   input  wire logic clock,    // Control clock.
   input  wire logic nrst,     // Asynchronous reset, active low.
   output logic      step_en   // One-cycle pulse every DIV cycles.
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_r;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_r <= '0;
      end
      else if (cnt_r == LAST)
      begin
         cnt_r <= '0;
      end
      else
      begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   assign step_en = (cnt_r == LAST);
endmodule

/* omr_gain_ramp.sv */
`timescale 1ns/1ps
module omr_gain_ramp #(
   parameter int W = omr_pkg::GAIN_W
) (
   input  wire logic         clock,    // Control clock.
   input  wire logic         nrst,     // Asynchronous reset, active low.
   input  wire logic         step_en,  // Pace pulse for one gain step.
   input  wire logic         hold,     // Freeze the applied value.
   input  wire logic [W-1:0] target,   // Programmed code.
   output logic      [W-1:0] applied,  // Code now in force.
   output logic              busy      // Applied differs from target.
);
   // One code per step keeps audible zipper noise down on large changes.
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         applied <= '0;
      end
      else if (step_en && !hold)
      begin
         if (applied < target)
         begin
            applied <= applied + W'(1);
         end
         else if (applied > target)
         begin
            applied <= applied - W'(1);
         end
      end
   end

   assign busy = (applied != target);
endmodule

/* omr_route_regs.sv */
`timescale 1ns/1ps
module omr_route_regs #(
   parameter int STEP_DIV = omr_pkg::STEP_CYCLES
) (
   input  wire logic                        clock,        // Control clock, 125 MHz.
   input  wire logic                        nrst,         // Register reset, active low.
   input  wire logic [omr_pkg::ADDR_W-1:0]  reg_addr,     // Register number.
   input  wire logic                        reg_wr,       // Write strobe, one cycle.
   input  wire logic [omr_pkg::DATA_W-1:0]  reg_wdata,    // Write data.
   input  wire logic                        reg_rd,       // Read strobe, one cycle.
   output logic      [omr_pkg::DATA_W-1:0]  reg_rdata,    // Read data, registered.
   output logic                             reg_rvalid,   // Read data valid pulse.
   output omr_pkg::omr_route_t [omr_pkg::N_ROUTES-1:0] route_applied, // Routes in force.
   output omr_pkg::omr_level_t              lcom_ctrl,    // Left common output control.
   output logic      [omr_pkg::LEVEL_W-1:0] lcom_level_applied, // Level in force.
   output logic                             lcom_drive_on, // Output stage active.
   output logic                             lcom_weak_cm  // Weak common-mode drive.
);
   localparam int NR = omr_pkg::N_ROUTES;
   localparam int NL = omr_pkg::N_LCOM_ROUTES;

   // Index of route register, or NR when the address is not a route.
   function automatic int route_index(input logic [omr_pkg::ADDR_W-1:0] a);
      int idx;
      idx = NR;
      case (a)
         omr_pkg::ADDR_LPGA_LCOM: idx = 0;
         omr_pkg::ADDR_LDAC_LCOM: idx = 1;
         omr_pkg::ADDR_RLN2_LCOM: idx = 2;
         omr_pkg::ADDR_RPGA_LCOM: idx = 3;
         omr_pkg::ADDR_RDAC_LCOM: idx = 4;
         omr_pkg::ADDR_LLN2_RHP:  idx = 5;
         omr_pkg::ADDR_LPGA_RHP:  idx = 6;
         default:                 idx = NR;
      endcase
      return idx;
   endfunction

   omr_pkg::omr_route_t [NR-1:0] route_r;
   logic [3:0]                   level_r;
   logic                         unmute_r;
   logic                         pd_hiz_r;
   logic                         power_r;
   logic                         pending_r;
   logic                         pending_nxt;
   logic                         step_en;
   logic [NR-1:0]                route_busy;
   logic                         level_busy;
   logic [omr_pkg::GAIN_W-1:0]   gain_applied [NR];
   omr_pkg::omr_state_t          state_r;
   omr_pkg::omr_state_t          state_nxt;
   logic                         wr_level;
   logic [omr_pkg::DATA_W-1:0]   rdata_nxt;

   assign wr_level = reg_wr && (reg_addr == omr_pkg::ADDR_LCOM_LEVEL);

   // Route registers: enable bit and gain code, all reset to zero.
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         route_r <= {NR{omr_pkg::ROUTE_RESET}};  // see [R8]
      end
      else if (reg_wr && route_index(reg_addr) < NR)
      begin
         route_r[route_index(reg_addr)] <= reg_wdata;  // see [R1] see [R2] see [R8]
      end
   end

   // Level control register; the pending bit is not written here.
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         level_r  <= omr_pkg::LEVEL_RESET;
         unmute_r <= omr_pkg::UNMUTE_RESET;
         pd_hiz_r <= omr_pkg::PD_HIZ_RESET;
         power_r  <= omr_pkg::POWER_RESET;
      end
      else if (wr_level)
      begin
         level_r  <= reg_wdata[omr_pkg::LEVEL_LSB +: omr_pkg::LEVEL_W];  // see [R9]
         unmute_r <= reg_wdata[omr_pkg::UNMUTE_BIT];  // see [R11]
         pd_hiz_r <= reg_wdata[omr_pkg::PD_HIZ_BIT];  // see [R12]
         power_r  <= reg_wdata[omr_pkg::POWER_BIT];   // see [R14]
      end
   end

   omr_step_div #(
      .DIV     (STEP_DIV)
   ) u_div (
      .clock   (clock),
      .nrst    (nrst),
      .step_en (step_en)
   );

   // Left common gains only move while that stage is powered; the others always may.
   generate
      for (genvar i = 0; i < NR; i++)
      begin : g_ramp
         omr_gain_ramp #(
            .W       (omr_pkg::GAIN_W)
         ) u_ramp (
            .clock   (clock),
            .nrst    (nrst),
            .step_en (step_en),
            .hold    ((i < NL) ? !power_r : 1'b0),
            .target  (route_r[i].gain),
            .applied (gain_applied[i]),
            .busy    (route_busy[i])
         );
         assign route_applied[i] = {route_r[i].en, gain_applied[i]};  // see [R3] see [R4] see [R5] see [R6] see [R7]
      end
   endgenerate

   omr_gain_ramp #(
      .W       (omr_pkg::LEVEL_W)
   ) u_level_ramp (
      .clock   (clock),
      .nrst    (nrst),
      .step_en (step_en),
      .hold    (!power_r),
      .target  (level_r),  // see [R10]
      .applied (lcom_level_applied),
      .busy    (level_busy)
   );

   // Tracks whether gain application is still in progress on the left common output.
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         omr_pkg::ST_IDLE:
            if (|route_busy[NL-1:0] || level_busy)
               state_nxt = power_r ? omr_pkg::ST_RAMP : omr_pkg::ST_HOLD;
         omr_pkg::ST_RAMP:
            if (!(|route_busy[NL-1:0] || level_busy))
               state_nxt = omr_pkg::ST_IDLE;
            else if (!power_r)
               state_nxt = omr_pkg::ST_HOLD;
         omr_pkg::ST_HOLD:
            if (!(|route_busy[NL-1:0] || level_busy))
               state_nxt = omr_pkg::ST_IDLE;
            else if (power_r)
               state_nxt = omr_pkg::ST_RAMP;
         default:
            state_nxt = omr_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state_r <= omr_pkg::ST_HOLD;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // Pending is set by reset and the left common ramps only; no bus write reaches it.
   assign pending_nxt = (state_nxt != omr_pkg::ST_IDLE);  // see [R13]

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         pending_r <= omr_pkg::PENDING_RESET;  // see [R13]
      end
      else
      begin
         pending_r <= pending_nxt;  // see [R15]
      end
   end

   // Read mux; unmapped addresses read zero.
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (route_index(reg_addr) < NR)
      begin
         rdata_nxt = route_r[route_index(reg_addr)];
      end
      else if (reg_addr == omr_pkg::ADDR_LCOM_LEVEL)
      begin
         rdata_nxt = {level_r, unmute_r, pd_hiz_r, pending_r, power_r};
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
         begin
            reg_rdata <= rdata_nxt;
         end
      end
   end

   assign lcom_ctrl         = {level_r, unmute_r, pd_hiz_r, pending_r, power_r};  // see [R11] see [R14]
   assign lcom_drive_on     = power_r;
   // Weak common-mode hold only applies while the stage is down.
   assign lcom_weak_cm      = !power_r && !pd_hiz_r;  // see [R12]
endmodule

/* omr_route_regs_properties.sv */
`timescale 1ns/1ps
module omr_route_regs_chk #(
   parameter int STEP_DIV = omr_pkg::STEP_CYCLES
) (
   input wire logic                               clock,              // Clock.
   input wire logic                               nrst,               // Reset.
   input wire logic [7:0]                         reg_addr,           // Address.
   input wire logic                               reg_wr,             // Write.
   input wire logic [7:0]                         reg_wdata,          // Write data.
   input wire logic                               reg_rd,             // Read.
   input wire logic [7:0]                         reg_rdata,          // Read data.
   input wire logic                               reg_rvalid,         // Read valid.
   input wire omr_pkg::omr_route_t [6:0]          route_applied,      // Routes.
   input wire omr_pkg::omr_level_t                lcom_ctrl,          // Level control.
   input wire logic [3:0]                         lcom_level_applied, // Level in force.
   input wire logic                               lcom_drive_on,      // Powered.
   input wire logic                               lcom_weak_cm        // Weak drive.
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!nrst);
   sequence s_lvl_wr;
      reg_wr && reg_addr == omr_pkg::ADDR_LCOM_LEVEL;
   endsequence
   sequence s_lvl_rd;
      reg_rd && reg_addr == omr_pkg::ADDR_LCOM_LEVEL;
   endsequence
   route_en_a: assert property (
      reg_wr && reg_addr == 8'h35 |=> route_applied[0].en == $past(reg_wdata[7]))
      else $error("route enable not taken");
   hp_en_a: assert property (
      reg_wr && reg_addr == 8'h3C |=> route_applied[6].en == $past(reg_wdata[7]))
      else $error("headphone route enable not taken");
   level_wr_a: assert property (
      s_lvl_wr |=> {lcom_ctrl.level, lcom_ctrl.unmute, lcom_ctrl.pd_hiz, lcom_ctrl.power}
      == {$past(reg_wdata[7:2]), $past(reg_wdata[0])})
      else $error("level control fields not written");
   rd_answer_a: assert property (
      s_lvl_rd |=> reg_rvalid && reg_rdata == $past(lcom_ctrl))
      else $error("level register read wrong");
   unmapped_rd_a: assert property (
      reg_rd && (reg_addr < 8'h35 || reg_addr > 8'h3C) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   rvalid_one_a: assert property (
      !reg_rd |=> !reg_rvalid)
      else $error("read valid without request");
   drive_on_a: assert property (
      lcom_drive_on == lcom_ctrl.power)
      else $error("drive does not follow power bit");
   weak_cm_a: assert property (
      lcom_weak_cm == (!lcom_ctrl.power && !lcom_ctrl.pd_hiz))
      else $error("weak drive wrong");
   // Stepping an unpowered stage would let the status bit clear with no gain applied.
   level_hold_a: assert property (
      !lcom_ctrl.power |=> $stable(lcom_level_applied))
      else $error("level stepped while unpowered");
   // The status bit may only drop once the level in force matched the programmed one.
   pending_clear_a: assert property (
      $fell(lcom_ctrl.pending) |-> $past(lcom_level_applied) == $past(lcom_ctrl.level))
      else $error("status cleared before level applied");
endmodule
bind omr_route_regs omr_route_regs_chk #(.STEP_DIV(STEP_DIV)) u_chk (.clock, .nrst,
   .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .route_applied,
   .lcom_ctrl, .lcom_level_applied, .lcom_drive_on, .lcom_weak_cm);

/* omr_host.sv */
`timescale 1ns/1ps
module omr_host (
   input  wire logic       clock,               // Control clock.
   output logic      [7:0] reg_addr  = 8'h00,   // Register number.
   output logic            reg_wr    = 1'b0,    // Write strobe.
   output logic      [7:0] reg_wdata = 8'h00,   // Write data.
   output logic            reg_rd    = 1'b0,    // Read strobe.
   input  wire logic [7:0] reg_rdata,           // Read data.
   input  wire logic       reg_rvalid           // Read valid.
);
   // Callers never pass level codes above 9 to the level register.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clock);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   // A missing valid pulse returns unknowns so the caller's compare fails.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clock);
      #1;
      reg_rd = 1'b0;
      d = reg_rvalid ? reg_rdata : 8'hXX;
   endtask
endmodule

/* omr_route_regs_bench.sv */
`timescale 1ns/1ps
module omr_route_regs_bench;
   logic                                       clock = 1'b0;
   logic                                       nrst  = 1'b0;
   logic [7:0]                                 reg_addr, reg_wdata, reg_rdata, d;
   logic                                       reg_wr, reg_rd, reg_rvalid;
   omr_pkg::omr_route_t [omr_pkg::N_ROUTES-1:0] route_applied;
   omr_pkg::omr_level_t                        lcom_ctrl;
   logic [3:0]                                 lvl_app;
   logic                                       drive_on, weak_cm;
   int                                         err_count  = 0;
   int                                         num_checks = 0;
   logic [7:0] addrs [7] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3B, 8'h3C};
   always #4 clock = ~clock;
   omr_route_regs #(.STEP_DIV(2)) u_dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .route_applied(route_applied), .lcom_ctrl(lcom_ctrl),
      .lcom_level_applied(lvl_app), .lcom_drive_on(drive_on), .lcom_weak_cm(weak_cm));
   omr_host u_host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Outputs are looked at 1 ns after the edge, once the new values have settled.
   task automatic wait_idle;
      for (int n = 0; n < 500 && lcom_ctrl.pending !== 1'b0; n++)
      begin
         @(posedge clock);
         #1;
      end
   endtask
   task automatic print_verdict;
      if (err_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #100000;
      err_count++;
      print_verdict();
   end
   initial
   begin
      repeat (4) @(posedge clock);
      #1;
      chk8(lcom_ctrl, 8'h06);
      chk8(route_applied[0], 8'h00);
      repeat (4) @(posedge clock);
      #1;
      nrst = 1'b1;
      for (int i = 0; i < 7; i++)
      begin
         u_host.rd(addrs[i], d);
         chk8(d, 8'h00);
      end
      u_host.rd(8'h3A, d);
      chk8(d, 8'h04);
      for (int i = 0; i < 7; i++)
      begin
         u_host.wr(addrs[i], 8'h81 + i[7:0]);
         chk8({route_applied[i].en, 7'h00}, 8'h80);
         u_host.rd(addrs[i], d);
         chk8(d, 8'h81 + i[7:0]);
      end
      u_host.wr(8'h3D, 8'hFF);
      u_host.rd(8'h3D, d);
      chk8(d, 8'h00);
      // Left common gains wait for power, so the status bit must still be set.
      repeat (40) @(posedge clock);
      u_host.rd(8'h3A, d);
      chk8(d, 8'h06);
      u_host.wr(8'h3A, 8'h9D);
      chk8({7'h00, lcom_ctrl.pending}, 8'h01);
      wait_idle();
      u_host.rd(8'h3A, d);
      chk8(d, 8'h9D);
      chk8({4'h0, lvl_app}, 8'h09);
      chk8({drive_on, weak_cm, 6'h00}, 8'h80);
      for (int i = 0; i < 7; i++)
         chk8(route_applied[i], 8'h81 + i[7:0]);
      // A new gain on a powered stage must raise the status bit until it lands.
      u_host.wr(8'h36, 8'h84);
      u_host.rd(8'h3A, d);
      chk8(d, 8'h9F);
      wait_idle();
      u_host.rd(8'h3A, d);
      chk8(d, 8'h9D);
      chk8(route_applied[1], 8'h84);
      u_host.wr(8'h3A, 8'h08);
      u_host.rd(8'h3A, d);
      chk8(d, 8'h0A);
      chk8({drive_on, weak_cm, 6'h00}, 8'h40);
      u_host.wr(8'h35, 8'h00);
      chk8({route_applied[0].en, 7'h00}, 8'h00);
      u_host.wr(8'h3C, 8'h00);
      chk8({route_applied[6].en, 7'h00}, 8'h00);
      // A reset in mid-run must bring the level register and route 0x3B back to their start values.
      nrst = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk8(lcom_ctrl, 8'h06);
      chk8({4'h0, lvl_app}, 8'h00);
      chk8(route_applied[5], 8'h00);
      nrst = 1'b1;
      u_host.rd(8'h3A, d);
      chk8(d, 8'h04);
      u_host.rd(8'h3B, d);
      chk8(d, 8'h00);
      print_verdict();
   end
endmodule
